/* rtl/rlm_monitor.sv */
`timescale 1ns/100ps
`default_nettype none

module rlm_monitor #(
   parameter int NUM_CH          = 16,
   parameter int TEMP_CNT_PER_DEG = 1
) (
   // System clock and reset.
   input  wire logic                sys_clk,
   input  wire logic                rst,
   // Conversion results on the converter clock.
   input  wire logic                adc_clk,
   input  wire logic                meas_valid,
   input  wire rlm_pkg::rlm_meas_t  meas,
   output logic                     meas_ready_q,
   // Command port from the bus engine.
   input  wire logic                cmd_valid,
   input  wire rlm_pkg::rlm_cmd_t   cmd,
   output logic                     resp_valid_q,
   output logic                     resp_ack_q,
   output logic [15:0]              resp_rdata_q,
   // Sequencer side.
   input  wire logic [NUM_CH-1:0]   chan_off,
   output logic [NUM_CH-1:0]        power_good_q,
   output logic [NUM_CH-1:0]        ton_cross_q,
   output logic                     margin_ok_q,
   output logic                     fault_evt_q,
   output logic [7:0]               fault_chan_q,
   output logic [15:0]              fault_act_q,
   // Alert line, pulled low while the enable is high.
   output logic                     alert_oe_q
);

   localparam int CW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
   localparam logic [16:0] OT_HYST =
      17'(rlm_pkg::OT_HYST_DEG * TEMP_CNT_PER_DEG);

   // Converter domain: hold the result until the system side acknowledges.
   rlm_pkg::rlm_meas_t hold_q;
   logic               req_tog_q;
   logic               ack_s1_q, ack_s2_q, ack_s3_q;
   logic               ack_tog_q;

   always_ff @(posedge adc_clk or posedge rst) begin
      if (rst) begin
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_s3_q <= 1'b0;
      end else begin
         ack_s1_q <= ack_tog_q;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
      end
   end

   always_ff @(posedge adc_clk or posedge rst) begin
      if (rst) begin
         hold_q       <= '0;
         req_tog_q    <= 1'b0;
         meas_ready_q <= 1'b1;
      end else if (meas_ready_q && meas_valid) begin
         hold_q       <= meas;
         req_tog_q    <= ~req_tog_q;
         meas_ready_q <= 1'b0;
      end else if (!meas_ready_q && ack_s2_q == ack_s3_q &&
                   ack_s3_q == req_tog_q) begin
         meas_ready_q <= 1'b1;
      end
   end

   // System domain: a new result is taken once the request toggle settles.
   logic req_s1_q, req_s2_q, req_s3_q;
   logic fire;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         req_s1_q  <= 1'b0;
         req_s2_q  <= 1'b0;
         req_s3_q  <= 1'b0;
         ack_tog_q <= 1'b0;
      end else begin
         req_s1_q  <= req_tog_q;
         req_s2_q  <= req_s1_q;
         req_s3_q  <= req_s2_q;
         if (fire) begin
            ack_tog_q <= req_s3_q;
         end
      end
   end

   assign fire = (req_s2_q == req_s3_q) && (req_s3_q != ack_tog_q) &&
                 (hold_q.chan < 8'(NUM_CH));

   // Limits and configuration, one set for each page, and one device-wide mode word.
   logic [15:0] uvf_thr_q [NUM_CH];
   logic [15:0] ocf_thr_q [NUM_CH];
   logic [15:0] ocw_thr_q [NUM_CH];
   logic [15:0] otf_thr_q [NUM_CH];
   logic [15:0] otw_thr_q [NUM_CH];
   logic [15:0] rise_q    [NUM_CH];
   logic [15:0] fall_q    [NUM_CH];
   logic [15:0] ton_dly_q [NUM_CH];
   logic [15:0] fa_cfg_q  [NUM_CH];
   logic [15:0] mode_q;

   logic          page_ok;
   logic [CW-1:0] pg;
   logic          wr;

   assign page_ok = cmd.page < 8'(NUM_CH);
   assign pg      = CW'(cmd.page);
   assign wr      = cmd_valid && cmd.write && page_ok;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int n = 0; n < NUM_CH; n++) begin
            uvf_thr_q[n] <= rlm_pkg::THR_RST_LOW;
            ocf_thr_q[n] <= rlm_pkg::THR_RST_HIGH;
            ocw_thr_q[n] <= rlm_pkg::THR_RST_HIGH;
            otf_thr_q[n] <= rlm_pkg::THR_RST_HIGH;
            otw_thr_q[n] <= rlm_pkg::THR_RST_HIGH;
            rise_q[n]    <= rlm_pkg::THR_RST_LOW;
            fall_q[n]    <= rlm_pkg::THR_RST_LOW;
            ton_dly_q[n] <= rlm_pkg::THR_RST_LOW;
            fa_cfg_q[n]  <= rlm_pkg::FA_RST;
         end
      end else if (wr) begin
         unique case (cmd.code)
            rlm_pkg::CMD_UV_FAULT_THR: uvf_thr_q[pg] <= cmd.wdata;
            rlm_pkg::CMD_OC_FAULT_THR: ocf_thr_q[pg] <= cmd.wdata;
            rlm_pkg::CMD_OC_WARN_THR:  ocw_thr_q[pg] <= cmd.wdata;
            rlm_pkg::CMD_OVERTEMPERATURE_FAULT_FLAG_THR: otf_thr_q[pg] <= cmd.wdata;
            rlm_pkg::CMD_OVERTEMPERATURE_WARNING_FLAG_THR:  otw_thr_q[pg] <= cmd.wdata;
            rlm_pkg::CMD_GOOD_RISE: begin
               rise_q[pg] <= cmd.wdata;
               if (cmd.wdata < fall_q[pg]) begin
                  fall_q[pg] <= cmd.wdata;
               end
            end
            rlm_pkg::CMD_GOOD_FALL: begin
               fall_q[pg] <= cmd.wdata;
               if (cmd.wdata > rise_q[pg]) begin
                  rise_q[pg] <= cmd.wdata;
               end
            end
            rlm_pkg::CMD_TURN_ON_DELAY_MS:    ton_dly_q[pg] <= cmd.wdata;
            rlm_pkg::CMD_FAULT_ACTION: fa_cfg_q[pg]  <= cmd.wdata;
            default: ;
         endcase
      end
   end

   // The mode word is device wide, so any page reaches it.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mode_q <= rlm_pkg::MODE_RST;
      end else if (cmd_valid && cmd.write &&
                   cmd.code == rlm_pkg::CMD_MODE_CONFIG) begin
         mode_q <= cmd.wdata;
      end
   end

   // Condition state, updated only when a result for the channel arrives.
   logic [NUM_CH-1:0] uvf_act_q, ocf_act_q, ocw_act_q, otf_act_q, otw_act_q;
   logic [NUM_CH-1:0] uv_armed_q, oc_armed_q, pgn_evt;
   logic [CW-1:0]     fc;
   logic [15:0]       v, i, t;
   logic [22:0]       v_x, uv_x, i_x, oc_x;
   logic [16:0]       t_clr;
   logic              new_fault;

   assign fc    = CW'(hold_q.chan);
   assign v     = hold_q.volt;
   assign i     = hold_q.curr;
   assign t     = hold_q.temp;
   assign v_x   = 23'(v) * rlm_pkg::UV_HYST_DEN;
   assign uv_x  = 23'(uvf_thr_q[fc]) * rlm_pkg::UV_HYST_NUM;
   assign i_x   = 23'(i) * rlm_pkg::OC_HYST_DEN;
   assign oc_x  = 23'(ocf_thr_q[fc]) * rlm_pkg::OC_HYST_NUM;
   assign t_clr = 17'(otf_thr_q[fc]) - OT_HYST;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         uvf_act_q  <= '0;
         uv_armed_q <= '0;
      end else if (fire) begin
         if (v > rise_q[fc]) begin
            uv_armed_q[fc] <= 1'b1;
         end
         if (!uv_armed_q[fc] || chan_off[fc]) begin
            uvf_act_q[fc] <= 1'b0;
         end else if (v < uvf_thr_q[fc]) begin
            uvf_act_q[fc] <= 1'b1;
         end else if (v_x >= uv_x) begin
            uvf_act_q[fc] <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ocf_act_q  <= '0;
         oc_armed_q <= '0;
      end else if (fire) begin
         if (!oc_armed_q[fc]) begin
            oc_armed_q[fc] <= (i < ocf_thr_q[fc]);
         end else if (i > ocf_thr_q[fc]) begin
            ocf_act_q[fc] <= 1'b1;
         end else if (i_x <= oc_x) begin
            ocf_act_q[fc] <= 1'b0;
         end
      end
   end

   // Warning uses its own threshold with the same 5 percent band.
   logic [22:0] ocw_x;
   assign ocw_x = 23'(ocw_thr_q[fc]) * rlm_pkg::OC_HYST_NUM;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ocw_act_q <= '0;
      end else if (fire) begin
         if (i > ocw_thr_q[fc]) begin
            ocw_act_q[fc] <= 1'b1;
         end else if (i_x <= ocw_x) begin
            ocw_act_q[fc] <= 1'b0;
         end
      end
   end

   // Temperatures are treated as unsigned counts; a flag whose threshold is below the band never clears.
   logic [16:0] tw_clr;
   assign tw_clr = 17'(otw_thr_q[fc]) - OT_HYST;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         otf_act_q <= '0;
         otw_act_q <= '0;
      end else if (fire) begin
         if (t > otf_thr_q[fc]) begin
            otf_act_q[fc] <= 1'b1;
         end else if (!t_clr[16] && 17'(t) <= t_clr) begin
            otf_act_q[fc] <= 1'b0;
         end
         if (t > otw_thr_q[fc]) begin
            otw_act_q[fc] <= 1'b1;
         end else if (!tw_clr[16] && 17'(t) <= tw_clr) begin
            otw_act_q[fc] <= 1'b0;
         end
      end
   end

   // Power-good tracking with separate rising and falling thresholds.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         power_good_q <= '0;
         ton_cross_q  <= '0;
      end else begin
         ton_cross_q <= '0;
         if (fire) begin
            if (!power_good_q[fc] && v > rise_q[fc]) begin
               power_good_q[fc] <= 1'b1;
               ton_cross_q[fc]  <= 1'b1;
            end else if (power_good_q[fc] && v < fall_q[fc]) begin
               power_good_q[fc] <= 1'b0;
            end
         end
      end
   end

   always_comb begin
      pgn_evt = '0;
      if (fire && power_good_q[fc] && v < fall_q[fc]) begin
         pgn_evt[fc] = 1'b1;
      end
   end

   // Latched detail bits; a condition still present sets its bit again.
   logic [NUM_CH-1:0] uvf_lat_q, ocf_lat_q, ocw_lat_q, otf_lat_q, otw_lat_q;
   logic [NUM_CH-1:0] pgn_lat_q;
   logic [NUM_CH-1:0] clr_v, clr_c_f, clr_c_w, clr_t_f, clr_t_w, clr_m;
   logic              clr_all;

   assign clr_all = cmd_valid && cmd.write &&
                    cmd.code == rlm_pkg::CMD_CLEAR_FAULTS;

   always_comb begin
      clr_v   = '0;
      clr_c_f = '0;
      clr_c_w = '0;
      clr_t_f = '0;
      clr_t_w = '0;
      clr_m   = '0;
      if (wr) begin
         unique case (cmd.code)
            rlm_pkg::CMD_VOLT_STATUS:
               clr_v[pg] = cmd.wdata[rlm_pkg::VS_UV_FAULT];
            rlm_pkg::CMD_CURR_STATUS: begin
               clr_c_f[pg] = cmd.wdata[rlm_pkg::CS_OC_FAULT];
               clr_c_w[pg] = cmd.wdata[rlm_pkg::CS_OC_WARN];
            end
            rlm_pkg::CMD_TEMP_STATUS: begin
               clr_t_f[pg] = cmd.wdata[rlm_pkg::TS_OVERTEMPERATURE_FAULT_FLAG];
               clr_t_w[pg] = cmd.wdata[rlm_pkg::TS_OVERTEMPERATURE_WARNING_FLAG];
            end
            rlm_pkg::CMD_VENDOR_STATUS:
               clr_m[pg] = cmd.wdata[rlm_pkg::MS_PNGOOD];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         uvf_lat_q <= '0;
         ocf_lat_q <= '0;
         ocw_lat_q <= '0;
         otf_lat_q <= '0;
         otw_lat_q <= '0;
         pgn_lat_q <= '0;
      end else begin
         uvf_lat_q <= (uvf_lat_q & ~(clr_v | {NUM_CH{clr_all}})) | uvf_act_q;
         ocf_lat_q <= (ocf_lat_q & ~(clr_c_f | {NUM_CH{clr_all}})) | ocf_act_q;
         ocw_lat_q <= (ocw_lat_q & ~(clr_c_w | {NUM_CH{clr_all}})) | ocw_act_q;
         otf_lat_q <= (otf_lat_q & ~(clr_t_f | {NUM_CH{clr_all}})) | otf_act_q;
         otw_lat_q <= (otw_lat_q & ~(clr_t_w | {NUM_CH{clr_all}})) | otw_act_q;
         pgn_lat_q <= (pgn_lat_q & ~(clr_m | {NUM_CH{clr_all}})) | pgn_evt;
      end
   end

   // Fault action request on each newly entered fault condition.
   assign new_fault = fire &&
      ((!uvf_act_q[fc] && uv_armed_q[fc] && !chan_off[fc] &&
        v < uvf_thr_q[fc]) ||
       (!ocf_act_q[fc] && oc_armed_q[fc] && i > ocf_thr_q[fc]) ||
       (!otf_act_q[fc] && t > otf_thr_q[fc]));

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fault_evt_q  <= 1'b0;
         fault_chan_q <= 8'h00;
         fault_act_q  <= 16'h0000;
      end else begin
         fault_evt_q <= new_fault;
         if (new_fault) begin
            fault_chan_q <= hold_q.chan;
            fault_act_q  <= fa_cfg_q[fc];
         end
      end
   end

   // Not-good is left out of the alert so sequencing off stays quiet.
   logic [NUM_CH-1:0] vmon;
   always_comb begin
      for (int k = 0; k < NUM_CH; k++) begin
         vmon[k] = fa_cfg_q[k][rlm_pkg::FA_VMON];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         alert_oe_q  <= 1'b0;
         margin_ok_q <= 1'b0;
      end else begin
         alert_oe_q <= mode_q[rlm_pkg::MODE_ALERT] &&
            |(uvf_lat_q | ocf_lat_q | ocw_lat_q | otf_lat_q | otw_lat_q);
         margin_ok_q <= &(power_good_q | ~vmon);
      end
   end

   // Read-back of limits and status for the addressed page.
   logic [15:0] rd;
   logic        rd_ok;

   always_comb begin
      rd    = 16'h0000;
      rd_ok = page_ok;
      unique case (cmd.code)
         rlm_pkg::CMD_UV_FAULT_THR:  rd = uvf_thr_q[pg];
         rlm_pkg::CMD_OC_FAULT_THR:  rd = ocf_thr_q[pg];
         rlm_pkg::CMD_OC_WARN_THR:   rd = ocw_thr_q[pg];
         rlm_pkg::CMD_OVERTEMPERATURE_FAULT_FLAG_THR:  rd = otf_thr_q[pg];
         rlm_pkg::CMD_OVERTEMPERATURE_WARNING_FLAG_THR:   rd = otw_thr_q[pg];
         rlm_pkg::CMD_GOOD_RISE:     rd = rise_q[pg];
         rlm_pkg::CMD_GOOD_FALL:     rd = fall_q[pg];
         rlm_pkg::CMD_TURN_ON_DELAY_MS:     rd = ton_dly_q[pg];
         rlm_pkg::CMD_FAULT_ACTION:  rd = fa_cfg_q[pg];
         rlm_pkg::CMD_MODE_CONFIG: begin
            rd    = mode_q;
            rd_ok = 1'b1;
         end
         rlm_pkg::CMD_STATUS_WORD: begin
            rd[rlm_pkg::SW_OUTPUT_VOLTAGE_SUMMARY_BIT]    = uvf_lat_q[pg];
            rd[rlm_pkg::SW_OUTPUT_CURRENT_SUMMARY_BIT]    = ocf_lat_q[pg] | ocw_lat_q[pg];
            rd[rlm_pkg::SW_PNGOOD]  = pgn_lat_q[pg];
            rd[rlm_pkg::SW_OUTPUT_CURRENT_SUMMARY_BIT_OC] = ocf_lat_q[pg];
            rd[rlm_pkg::SW_TEMP]    = otf_lat_q[pg] | otw_lat_q[pg];
         end
         rlm_pkg::CMD_VOLT_STATUS:
            rd[rlm_pkg::VS_UV_FAULT] = uvf_lat_q[pg];
         rlm_pkg::CMD_CURR_STATUS: begin
            rd[rlm_pkg::CS_OC_FAULT] = ocf_lat_q[pg];
            rd[rlm_pkg::CS_OC_WARN]  = ocw_lat_q[pg];
         end
         rlm_pkg::CMD_TEMP_STATUS: begin
            rd[rlm_pkg::TS_OVERTEMPERATURE_FAULT_FLAG] = otf_lat_q[pg];
            rd[rlm_pkg::TS_OVERTEMPERATURE_WARNING_FLAG]  = otw_lat_q[pg];
         end
         rlm_pkg::CMD_VENDOR_STATUS:
            rd[rlm_pkg::MS_PNGOOD] = pgn_lat_q[pg];
         rlm_pkg::CMD_CLEAR_FAULTS:
            rd_ok = 1'b1;
         default:
            rd_ok = 1'b0;
      endcase
      if (!rd_ok) begin
         rd = 16'h0000;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         resp_valid_q <= 1'b0;
         resp_ack_q   <= 1'b0;
         resp_rdata_q <= 16'h0000;
      end else begin
         resp_valid_q <= cmd_valid;
         if (cmd_valid) begin
            resp_ack_q   <= rd_ok;
            resp_rdata_q <= cmd.write ? 16'h0000 : rd;
         end
      end
   end

endmodule // rlm_monitor

`default_nettype wire

/* rtl/rlm_pkg.sv */
package rlm_pkg;

   // Command codes of the limit, status, configuration and clear commands.
   localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
   localparam logic [7:0] CMD_UV_FAULT_THR  = 8'h44;
   localparam logic [7:0] CMD_OC_FAULT_THR  = 8'h46;
   localparam logic [7:0] CMD_OC_WARN_THR   = 8'h4a;
   localparam logic [7:0] CMD_OVERTEMPERATURE_FAULT_FLAG_THR  = 8'h4f;
   localparam logic [7:0] CMD_OVERTEMPERATURE_WARNING_FLAG_THR   = 8'h51;
   localparam logic [7:0] CMD_GOOD_RISE     = 8'h5e;
   localparam logic [7:0] CMD_GOOD_FALL     = 8'h5f;
   localparam logic [7:0] CMD_TURN_ON_DELAY_MS     = 8'h60;
   localparam logic [7:0] CMD_STATUS_WORD   = 8'h79;
   localparam logic [7:0] CMD_VOLT_STATUS   = 8'h7a;
   localparam logic [7:0] CMD_CURR_STATUS   = 8'h7b;
   localparam logic [7:0] CMD_TEMP_STATUS   = 8'h7d;
   localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
   localparam logic [7:0] CMD_MODE_CONFIG   = 8'hd1;
   localparam logic [7:0] CMD_FAULT_ACTION  = 8'hd5;

   // Bit positions in the summary word, the detail bytes, the mode word and the fault action word.
   localparam int SW_OUTPUT_VOLTAGE_SUMMARY_BIT     = 15;
   localparam int SW_OUTPUT_CURRENT_SUMMARY_BIT     = 14;
   localparam int SW_PNGOOD   = 11;
   localparam int SW_OUTPUT_CURRENT_SUMMARY_BIT_OC  = 4;
   localparam int SW_TEMP     = 2;
   localparam int VS_UV_FAULT = 4;
   localparam int CS_OC_FAULT = 7;
   localparam int CS_OC_WARN  = 5;
   localparam int TS_OVERTEMPERATURE_FAULT_FLAG = 7;
   localparam int TS_OVERTEMPERATURE_WARNING_FLAG  = 6;
   localparam int MS_PNGOOD   = 3;
   localparam int MODE_ALERT  = 0;
   localparam int FA_SHUTDOWN = 0;
   localparam int FA_VMON     = 1;

   // Values after reset.
   localparam logic [15:0] THR_RST_LOW  = 16'h0000;
   localparam logic [15:0] THR_RST_HIGH = 16'h7fff;
   localparam logic [15:0] MODE_RST     = 16'h0001;
   localparam logic [15:0] FA_RST       = 16'h0002;

   // Hysteresis as ratios: 2 percent above, 5 percent below, 4 degrees.
   localparam logic [22:0] UV_HYST_NUM = 23'h000033;
   localparam logic [22:0] UV_HYST_DEN = 23'h000032;
   localparam logic [22:0] OC_HYST_NUM = 23'h000013;
   localparam logic [22:0] OC_HYST_DEN = 23'h000014;
   localparam int          OT_HYST_DEG = 4;

   typedef struct packed {
      logic        write;
      logic [7:0]  code;
      logic [7:0]  page;
      logic [15:0] wdata;
   } rlm_cmd_t;

   typedef struct packed {
      logic [7:0]  chan;
      logic [15:0] volt;
      logic [15:0] curr;
      logic [15:0] temp;
   } rlm_meas_t;

endpackage

/* test/rlm_adc_model.sv */
`timescale 1ns/100ps
`default_nettype none

module rlm_adc_model (
   // Converter side of the result link.
   input  wire logic          adc_clk,
   input  wire logic          meas_ready_q,
   output rlm_pkg::rlm_meas_t meas,
   output logic               meas_valid
);
   initial begin
      meas_valid = 1'b0;
      meas = '0;
   end

   // After release the bus shows the inverse, so a late sample is caught.
   task automatic send(input rlm_pkg::rlm_meas_t m, output bit ok);
      @(posedge adc_clk);
      meas_valid <= 1'b1;
      meas <= m;
      ok = 1'b0;
      for (int n = 0; n < 50 && !ok; n++) begin
         @(posedge adc_clk);
         ok = (meas_ready_q === 1'b1);
      end
      meas_valid <= 1'b0;
      meas <= ~m;
   endtask
endmodule // rlm_adc_model

`default_nettype wire

/* test/rlm_monitor_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module rlm_monitor_bench;
   localparam int NCH = 2;

   logic               sys_clk = 1'b0, adc_clk = 1'b0, rst = 1'b1;
   logic               cmd_valid = 1'b0, meas_valid, meas_ready_q;
   rlm_pkg::rlm_cmd_t  cmd = '0;
   rlm_pkg::rlm_meas_t meas;
   logic [NCH-1:0]     chan_off = '0, power_good_q, ton_cross_q;
   logic               resp_valid_q, resp_ack_q, margin_ok_q;
   logic               fault_evt_q, alert_oe_q;
   logic [7:0]         fault_chan_q;
   logic [15:0]        resp_rdata_q, fault_act_q, rd;
   int                 fails = 0, total_checks = 0;
   int                 n_evt = 0;
   bit                 ok;

   always #5 sys_clk = ~sys_clk;

   // Fault events are one-cycle pulses, so they are counted as they pass.
   always @(negedge sys_clk) begin
      if (fault_evt_q === 1'b1) n_evt++;
   end
   initial begin
      #2.3;
      forever #6 adc_clk = ~adc_clk;
   end

   rlm_monitor #(.NUM_CH(NCH)) rlm_monitor_i (
      .sys_clk(sys_clk), .rst(rst), .adc_clk(adc_clk),
      .meas_valid(meas_valid), .meas(meas), .meas_ready_q(meas_ready_q),
      .cmd_valid(cmd_valid), .cmd(cmd), .resp_valid_q(resp_valid_q),
      .resp_ack_q(resp_ack_q), .resp_rdata_q(resp_rdata_q),
      .chan_off(chan_off), .power_good_q(power_good_q),
      .ton_cross_q(ton_cross_q), .margin_ok_q(margin_ok_q),
      .fault_evt_q(fault_evt_q), .fault_chan_q(fault_chan_q),
      .fault_act_q(fault_act_q), .alert_oe_q(alert_oe_q));
   rlm_adc_model rlm_adc_model_i (
      .adc_clk(adc_clk), .meas_ready_q(meas_ready_q),
      .meas(meas), .meas_valid(meas_valid));

   task automatic close_out();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task automatic xfer(input logic wr, input logic [7:0] code, pg,
                       input logic [15:0] wd);
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd = '{wr, code, pg, wd};
      @(negedge sys_clk);
      chk("resp_valid", {15'h0000, resp_valid_q}, 16'h0001);
      rd = resp_rdata_q;
      cmd_valid = 1'b0;
      @(negedge sys_clk);
      chk("resp_end", {15'h0000, resp_valid_q}, 16'h0000);
   endtask

   task automatic wr(input logic [7:0] code, input logic [15:0] d);
      xfer(1'b1, code, 8'h00, d);
   endtask

   task automatic rdchk(input string what, input logic [7:0] code,
                        input logic [15:0] exp);
      xfer(1'b0, code, 8'h00, 16'h0000);
      chk(what, rd, exp);
   endtask

   // Waits for the link to hand back ready, so evaluation has finished.
   task automatic put(input logic [7:0] ch, input logic [15:0] v, i, t);
      rlm_adc_model_i.send('{ch, v, i, t}, ok);
      repeat (3) @(negedge sys_clk);
      for (int n = 0; n < 40 && meas_ready_q !== 1'b1; n++)
         @(negedge sys_clk);
      if (!ok || meas_ready_q !== 1'b1) begin
         fails++;
         close_out();
      end
      repeat (3) @(negedge sys_clk);
   endtask

   task automatic s_regs();
      rdchk("uv_thr", 8'h44, 16'h0000);
      wr(8'h4a, 16'h1234);
      rdchk("oc_warn", 8'h4a, 16'h1234);
      rdchk("oc_fault", 8'h46, 16'h7fff);
      wr(8'h60, 16'h0005);
      rdchk("ton_dly", 8'h60, 16'h0005);
      xfer(1'b0, 8'h44, 8'(NCH), 16'h0000);
      chk("bad_page", {15'h0000, resp_ack_q}, 16'h0000);
      wr(8'h5e, 16'h0100);
      wr(8'h5f, 16'h0200);
      rdchk("rise", 8'h5e, 16'h0200);
      wr(8'h5e, 16'h0080);
      rdchk("fall", 8'h5f, 16'h0080);
   endtask

   task automatic s_oc();
      wr(8'h46, 16'h0100);
      wr(8'h4a, 16'h0080);
      wr(8'hd5, 16'h0003);
      put(8'h00, 16'h0000, 16'h0200, 16'h0000);
      rdchk("cur_stat", 8'h7b, 16'h0020);
      put(8'h00, 16'h0000, 16'h0050, 16'h0000);
      put(8'h00, 16'h0000, 16'h0101, 16'h0000);
      rdchk("cur_stat", 8'h7b, 16'h00a0);
      chk("evt_count", 16'(n_evt), 16'h0001);
      chk("fault_act", fault_act_q, 16'h0003);
      rdchk("word", 8'h79, 16'h4010);
      put(8'h00, 16'h0000, 16'h00f3, 16'h0000);
      wr(8'h7b, 16'h00ff);
      rdchk("cur_stat", 8'h7b, 16'h0020);
      put(8'h00, 16'h0000, 16'h0079, 16'h0000);
      wr(8'h03, 16'h0000);
      rdchk("cur_stat", 8'h7b, 16'h0000);
   endtask

   task automatic s_uv();
      wr(8'h5e, 16'h0100);
      wr(8'h44, 16'h00c8);
      put(8'h00, 16'h0050, 16'h0000, 16'h0000);
      rdchk("volt_stat", 8'h7a, 16'h0000);
      put(8'h00, 16'h0120, 16'h0000, 16'h0000);
      chk("good", {14'h0000, power_good_q}, 16'h0001);
      chk("margin", {15'h0000, margin_ok_q}, 16'h0000);
      put(8'h01, 16'h0120, 16'h0000, 16'h0000);
      chk("margin", {15'h0000, margin_ok_q}, 16'h0001);
      chan_off = 2'b01;
      put(8'h00, 16'h00c0, 16'h0000, 16'h0000);
      rdchk("volt_stat", 8'h7a, 16'h0000);
      chan_off = 2'b00;
      put(8'h00, 16'h00c0, 16'h0000, 16'h0000);
      rdchk("volt_stat", 8'h7a, 16'h0010);
      rdchk("word", 8'h79, 16'h8000);
      chk("alert", {15'h0000, alert_oe_q}, 16'h0001);
      put(8'h00, 16'h00cb, 16'h0000, 16'h0000);
      wr(8'h7a, 16'h0010);
      rdchk("volt_stat", 8'h7a, 16'h0010);
      put(8'h00, 16'h00cc, 16'h0000, 16'h0000);
      wr(8'h7a, 16'h0010);
      rdchk("volt_stat", 8'h7a, 16'h0000);
      chan_off = 2'b01;
      put(8'h00, 16'h0070, 16'h0000, 16'h0000);
      chk("good", {14'h0000, power_good_q}, 16'h0002);
      rdchk("vend_stat", 8'h80, 16'h0008);
      rdchk("word", 8'h79, 16'h0800);
      chk("alert", {15'h0000, alert_oe_q}, 16'h0000);
   endtask

   task automatic s_ot();
      wr(8'h03, 16'h0000);
      wr(8'hd1, 16'h0000);
      wr(8'h4f, 16'h0100);
      wr(8'h51, 16'h00f0);
      put(8'h00, 16'h0070, 16'h0000, 16'h0101);
      rdchk("temp_stat", 8'h7d, 16'h00c0);
      chk("alert", {15'h0000, alert_oe_q}, 16'h0000);
      put(8'h00, 16'h0070, 16'h0000, 16'h00fd);
      wr(8'h7d, 16'h00ff);
      rdchk("temp_stat", 8'h7d, 16'h00c0);
      wr(8'hd1, 16'h0001);
      chk("alert", {15'h0000, alert_oe_q}, 16'h0001);
      put(8'h00, 16'h0070, 16'h0000, 16'h00ec);
      wr(8'h7d, 16'h00ff);
      rdchk("temp_stat", 8'h7d, 16'h0000);
      xfer(1'b1, 8'h4f, 8'h01, 16'h0100);
      put(8'h01, 16'h0120, 16'h0000, 16'h0101);
      chk("fault_chan", {8'h00, fault_chan_q}, 16'h0001);
      chk("fault_act", fault_act_q, 16'h0002);
      chk("evt_count", 16'(n_evt), 16'h0004);
   endtask

   initial begin
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      s_regs();
      s_oc();
      s_uv();
      s_ot();
      close_out();
   end
endmodule // rlm_monitor_bench

`default_nettype wire

/* test/rlm_monitor_sva.sv */
`timescale 1ns/100ps
`default_nettype none

module rlm_monitor_sva #(
   parameter int NUM_CH = 16
) (
   // Clock and reset.
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Command port.
   input  wire logic              cmd_valid,
   input  wire rlm_pkg::rlm_cmd_t cmd,
   input  wire logic              resp_valid_q,
   input  wire logic              resp_ack_q,
   input  wire logic [15:0]       resp_rdata_q,
   // Monitor outputs.
   input  wire logic [NUM_CH-1:0] power_good_q,
   input  wire logic [NUM_CH-1:0] ton_cross_q,
   input  wire logic              fault_evt_q,
   input  wire logic [7:0]        fault_chan_q,
   input  wire logic              alert_oe_q
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   logic alert_en_q;

   // Mirrors the device-wide alert enable, which is not visible at a port.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         alert_en_q <= 1'b1;
      end else if (cmd_valid && cmd.write && cmd.code == 8'hd1) begin
         alert_en_q <= cmd.wdata[rlm_pkg::MODE_ALERT];
      end
   end

   sequence s_lone_cmd;
      cmd_valid ##1 !cmd_valid;
   endsequence

   sequence s_one_resp;
      resp_valid_q ##1 !resp_valid_q;
   endsequence

   a_resp_timing: assert property (s_lone_cmd |-> s_one_resp)
      else $error("response pulse wrong");
   a_write_rdata: assert property (cmd_valid && cmd.write |=>
      resp_rdata_q == 16'h0000) else $error("write data not zero");
   a_bad_page: assert property (cmd_valid && cmd.page >= NUM_CH &&
      !(cmd.code inside {8'hd1, 8'h03}) |=> !resp_ack_q)
      else $error("bad page acknowledged");
   a_limit_ack: assert property (cmd_valid && cmd.page == 8'h00 &&
      cmd.code inside {8'h44, 8'h46, 8'h4a} |=> resp_ack_q)
      else $error("limit code refused");
   a_ton_rise: assert property (ton_cross_q != '0 |->
      ton_cross_q == (power_good_q & ~$past(power_good_q)))
      else $error("crossing without rise");
   a_evt_single: assert property (fault_evt_q |=> !fault_evt_q)
      else $error("fault event too long");
   a_evt_chan: assert property ($rose(fault_evt_q) |->
      fault_chan_q < NUM_CH) else $error("fault channel out of range");
   a_alert_gate: assert property (alert_oe_q |-> alert_en_q ||
      $past(alert_en_q) || $past(alert_en_q, 2))
      else $error("alert while disabled");
endmodule // rlm_monitor_sva

bind rlm_monitor rlm_monitor_sva #(.NUM_CH(NUM_CH)) rlm_monitor_sva_i (
   .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
   .resp_valid_q(resp_valid_q), .resp_ack_q(resp_ack_q),
   .resp_rdata_q(resp_rdata_q), .power_good_q(power_good_q),
   .ton_cross_q(ton_cross_q), .fault_evt_q(fault_evt_q),
   .fault_chan_q(fault_chan_q), .alert_oe_q(alert_oe_q));

`default_nettype wire
